// *** plk_pkg.sv ***
// constants for the link side of the phy to link interface
package plk_pkg;
	// control pair codes while the phy drives
	localparam logic [1:0] CTL_IDLE = 2'h0;
	localparam logic [1:0] CTL_STATUS = 2'h1;
	localparam logic [1:0] CTL_RECEIVE = 2'h2;
	localparam logic [1:0] CTL_GRANT = 2'h3;
	// control pair codes while the link drives
	localparam logic [1:0] LCTL_RELEASE = 2'h0;
	localparam logic [1:0] LCTL_HOLD = 2'h1;
	localparam logic [1:0] LCTL_TRANSMIT = 2'h2;
	localparam logic [1:0] LCTL_RSVD = 2'h3;
	// request type codes
	localparam logic [2:0] REQ_IMM = 3'h0;
	localparam logic [2:0] REQ_ISO = 3'h1;
	localparam logic [2:0] REQ_PRI = 3'h2;
	localparam logic [2:0] REQ_FAIR = 3'h3;
	localparam logic [2:0] REQ_RD = 3'h4;
	localparam logic [2:0] REQ_WR = 3'h5;
	localparam logic [2:0] REQ_ACC = 3'h6;
	localparam logic [2:0] REQ_RSVD = 3'h7;
	// bus request speed codes
	localparam logic [2:0] SPD_S100 = 3'h0;
	localparam logic [2:0] SPD_S200 = 3'h2;
	localparam logic [2:0] SPD_S400 = 3'h4;
	// request lengths in bits
	localparam int FRAME_W = 17;
	localparam int LEN_W = 5;
	localparam logic [4:0] LEN_BUS_CABLE = 5'h07;
	localparam logic [4:0] LEN_BUS_BP = 5'h0b;
	localparam logic [4:0] LEN_RD = 5'h09;
	localparam logic [4:0] LEN_WR = 5'h11;
	localparam logic [4:0] LEN_ACC = 5'h06;
	localparam logic [4:0] LEN_NONE = 5'h00;
	// data lanes in use per speed
	localparam int DATA_W = 8;
	localparam logic [3:0] LANES_S100 = 4'h2;
	localparam logic [3:0] LANES_S200 = 4'h4;
	localparam logic [3:0] LANES_S400 = 4'h8;
	// link clock edges to wait for a request bit, for checks
	localparam int BIT_WAIT_MAX = 32;
endpackage : plk_pkg

// *** plk_req_ser.sv ***
// serial request shifter for the request line
`timescale 1ns/100ps
module plk_req_ser #(
	parameter int FRAME_W = plk_pkg::FRAME_W,
	parameter int LEN_W = plk_pkg::LEN_W
) (
	// clock and reset
	input logic sys_clk_in,
	input logic rst_in,
	// control
	input logic bit_en_in,
	input logic start_in,
	input logic [FRAME_W-1:0] frame_in,
	input logic [LEN_W-1:0] len_in,
	// status and line
	output logic line_out,
	output logic busy_out
);
	initial begin
		if (FRAME_W < 2 || (1 << LEN_W) <= FRAME_W) $error("plk_req_ser: bad widths");
	end

	logic [FRAME_W-1:0] sh_r, sh_nxt;
	logic [LEN_W-1:0] cnt_r, cnt_nxt;
	logic line_r, line_nxt;
	logic busy;
	localparam int BIT_WAIT = plk_pkg::BIT_WAIT_MAX;

	assign busy = (cnt_r != '0) || line_r;
	assign busy_out = busy;
	assign line_out = line_r;

	always_comb begin
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		line_nxt = line_r;
		if (start_in && !busy && len_in != '0) begin
			sh_nxt = frame_in;
			cnt_nxt = len_in;
		end else if (bit_en_in) begin
			if (cnt_r != '0) begin
				line_nxt = sh_r[FRAME_W-1];
				sh_nxt = {sh_r[FRAME_W-2:0], 1'b0};
				cnt_nxt = cnt_r - 1'b1;
			end else begin
				line_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			sh_r <= '0;
			cnt_r <= '0;
			line_r <= 1'b0;
		end else begin
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
			line_r <= line_nxt;
		end
	end

	property p_idle_low;
		@(posedge sys_clk_in) disable iff (rst_in)
		cnt_r == '0 && bit_en_in |=> !line_r;
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("request line high while idle");

	sequence s_req_start;
		start_in && !busy && len_in != '0;
	endsequence
	property p_start_bit;
		@(posedge sys_clk_in) disable iff (rst_in)
		s_req_start |=> !line_r ##[1:BIT_WAIT] line_r;
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("start bit not sent");
endmodule : plk_req_ser

// *** plk_link.sv ***
// link side of the phy to link interface
`timescale 1ns/100ps
module plk_link (
	// clock and reset
	input logic sys_clk_in,
	input logic rst_in,
	// phy side pins
	input logic phy_supplied_clock_in,
	input logic [1:0] link_control_pair_in,
	output logic [1:0] link_control_pair_out,
	output logic link_control_pair_oe_out,
	input logic [7:0] link_data_lanes_in,
	output logic [7:0] link_data_lanes_out,
	output logic link_data_lanes_oe_out,
	output logic link_service_request_line_out,
	output logic link_power_indicator_out,
	// power state
	input logic power_on_in,
	// service requests
	input logic req_valid_in,
	input logic [2:0] req_type_in,
	input logic [2:0] req_speed_in,
	input logic [3:0] req_addr_in,
	input logic [7:0] req_data_in,
	input logic [3:0] req_prio_in,
	input logic req_backplane_in,
	input logic req_accel_en_in,
	output logic req_ready_out,
	// transmit bytes
	input logic tx_valid_in,
	input logic [7:0] tx_data_in,
	input logic tx_last_in,
	input logic tx_concat_in,
	output logic tx_ready_out,
	// status and receive symbols
	output logic rx_strobe_out,
	output logic rx_status_out,
	output logic [7:0] rx_data_out
);
	typedef enum logic [1:0] {ST_OFF, ST_HOLD, ST_TX, ST_REL} plk_state_t;

	function automatic logic [3:0] lanes_of(input logic [2:0] spd);
		if (spd == plk_pkg::SPD_S400) lanes_of = plk_pkg::LANES_S400;
		else if (spd == plk_pkg::SPD_S200) lanes_of = plk_pkg::LANES_S200;
		else lanes_of = plk_pkg::LANES_S100;
	endfunction : lanes_of

	function automatic logic [7:0] chunk(input logic [7:0] sh, input logic [3:0] w);
		if (w == plk_pkg::LANES_S400) chunk = sh;
		else if (w == plk_pkg::LANES_S200) chunk = {4'hf, sh[7:4]};
		else chunk = {6'h3f, sh[7:6]};
	endfunction : chunk

	function automatic logic [7:0] shl(input logic [7:0] sh, input logic [3:0] w);
		if (w == plk_pkg::LANES_S400) shl = 8'h00;
		else if (w == plk_pkg::LANES_S200) shl = {sh[3:0], 4'h0};
		else shl = {sh[5:0], 2'h0};
	endfunction : shl

	function automatic logic [2:0] chunks_of(input logic [3:0] w);
		if (w == plk_pkg::LANES_S400) chunks_of = 3'h0;
		else if (w == plk_pkg::LANES_S200) chunks_of = 3'h1;
		else chunks_of = 3'h3;
	endfunction : chunks_of

	// synchronisers for pins on the interface clock
	logic [2:0] ck_s;
	logic [1:0] ctl_s0, ctl_s1;
	logic [7:0] dat_s0, dat_s1;
	logic ph_en;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ck_s <= 3'h0;
			ctl_s0 <= 2'h0;
			ctl_s1 <= 2'h0;
			dat_s0 <= 8'h00;
			dat_s1 <= 8'h00;
		end else begin
			ck_s <= {ck_s[1:0], phy_supplied_clock_in};
			ctl_s0 <= link_control_pair_in;
			ctl_s1 <= ctl_s0;
			dat_s0 <= link_data_lanes_in;
			dat_s1 <= dat_s0;
		end
	end
	assign ph_en = ck_s[1] & ~ck_s[2];

	// request framing
	logic req_take, ser_busy;
	logic [21:0] req_fr;

	function automatic logic [21:0] build(input logic [2:0] t, input logic [2:0] spd,
		input logic [3:0] a, input logic [7:0] d, input logic [3:0] p, input logic bp,
		input logic acc);
		if (t <= plk_pkg::REQ_FAIR) begin
			if (bp) build = {plk_pkg::LEN_BUS_BP, 1'b1, t, spd, p, 6'h00};
			else build = {plk_pkg::LEN_BUS_CABLE, 1'b1, t, spd, 4'h0, 6'h00};
		end else if (t == plk_pkg::REQ_RD) begin
			build = {plk_pkg::LEN_RD, 1'b1, t, a, 9'h000};
		end else if (t == plk_pkg::REQ_WR) begin
			build = {plk_pkg::LEN_WR, 1'b1, t, a, d, 1'b0};
		end else if (t == plk_pkg::REQ_ACC) begin
			build = {plk_pkg::LEN_ACC, 1'b1, t, acc, 12'h000};
		end else begin
			build = {plk_pkg::LEN_NONE, 17'h00000};
		end
	endfunction : build

	assign req_take = req_valid_in && req_ready_out && link_power_indicator_out;
	assign req_fr = build(req_type_in, req_speed_in, req_addr_in, req_data_in, req_prio_in,
		req_backplane_in, req_accel_en_in);

	plk_req_ser u_ser (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.bit_en_in(ph_en),
		.start_in(req_take),
		.frame_in(req_fr[16:0]),
		.len_in(req_fr[21:17]),
		.line_out(link_service_request_line_out),
		.busy_out(ser_busy)
	);

	// bus ownership, transmit and receive
	plk_state_t state_r, state_nxt;
	logic [1:0] ctl_r, ctl_nxt;
	logic oe_r, oe_nxt;
	logic [7:0] dout_r, dout_nxt, sh_r, sh_nxt, buf_r, buf_nxt;
	logic [2:0] chunks_r, chunks_nxt;
	logic last_r, last_nxt, cat_r, cat_nxt, bl_r, bl_nxt, bc_r, bc_nxt;
	logic bfull_r, bfull_nxt, txrdy_r, txrdy_nxt, rqrdy_r, rqrdy_nxt;
	logic [3:0] width_r, width_nxt;
	logic rxs_r, rxs_nxt, rxst_r, rxst_nxt, pwr_r, pwr_nxt;
	logic [7:0] rxd_r, rxd_nxt;

	always_comb begin
		state_nxt = state_r;
		ctl_nxt = ctl_r;
		oe_nxt = oe_r;
		dout_nxt = dout_r;
		sh_nxt = sh_r;
		chunks_nxt = chunks_r;
		last_nxt = last_r;
		cat_nxt = cat_r;
		buf_nxt = buf_r;
		bl_nxt = bl_r;
		bc_nxt = bc_r;
		bfull_nxt = bfull_r;
		width_nxt = width_r;
		rxs_nxt = 1'b0;
		rxst_nxt = rxst_r;
		rxd_nxt = rxd_r;
		pwr_nxt = power_on_in;
		rqrdy_nxt = !ser_busy && !req_take && power_on_in;
		if (req_take && req_type_in <= plk_pkg::REQ_FAIR) begin
			width_nxt = lanes_of(req_speed_in);
		end
		if (tx_valid_in && txrdy_r) begin
			buf_nxt = tx_data_in;
			bl_nxt = tx_last_in;
			bc_nxt = tx_concat_in;
			bfull_nxt = 1'b1;
		end
		if (!pwr_r) begin
			state_nxt = ST_OFF;
			oe_nxt = 1'b0;
			bfull_nxt = 1'b0;
		end else if (ph_en) begin
			case (state_r)
				ST_OFF: begin
					if (ctl_s1 == plk_pkg::CTL_GRANT) begin
						state_nxt = ST_HOLD;
						oe_nxt = 1'b1;
						ctl_nxt = plk_pkg::LCTL_HOLD;
						dout_nxt = chunk(8'h00, width_r);
					end else if (ctl_s1 == plk_pkg::CTL_STATUS ||
						ctl_s1 == plk_pkg::CTL_RECEIVE) begin
						rxs_nxt = 1'b1;
						rxst_nxt = (ctl_s1 == plk_pkg::CTL_STATUS);
						rxd_nxt = dat_s1;
					end
				end
				ST_HOLD, ST_TX: begin
					if (state_r == ST_TX && chunks_r != 3'h0) begin
						sh_nxt = shl(sh_r, width_r);
						chunks_nxt = chunks_r - 3'h1;
						dout_nxt = chunk(sh_nxt, width_r);
					end else if (state_r == ST_TX && last_r) begin
						state_nxt = cat_r ? ST_HOLD : ST_REL;
						ctl_nxt = cat_r ? plk_pkg::LCTL_HOLD : plk_pkg::LCTL_RELEASE;
						dout_nxt = chunk(8'h00, width_r);
						last_nxt = 1'b0;
					end else if (bfull_r) begin
						state_nxt = ST_TX;
						ctl_nxt = plk_pkg::LCTL_TRANSMIT;
						sh_nxt = buf_r;
						chunks_nxt = chunks_of(width_r);
						dout_nxt = chunk(buf_r, width_r);
						last_nxt = bl_r;
						cat_nxt = bc_r;
						bfull_nxt = 1'b0;
					end else begin
						state_nxt = ST_HOLD;
						ctl_nxt = plk_pkg::LCTL_HOLD;
						dout_nxt = chunk(8'h00, width_r);
					end
				end
				ST_REL: begin
					state_nxt = ST_OFF;
					oe_nxt = 1'b0;
				end
				default: begin
					state_nxt = ST_OFF;
					oe_nxt = 1'b0;
				end
			endcase
		end
		txrdy_nxt = !bfull_nxt && pwr_r;
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_r <= ST_OFF;
			ctl_r <= plk_pkg::LCTL_RELEASE;
			oe_r <= 1'b0;
			dout_r <= 8'h00;
			sh_r <= 8'h00;
			chunks_r <= 3'h0;
			last_r <= 1'b0;
			cat_r <= 1'b0;
			buf_r <= 8'h00;
			bl_r <= 1'b0;
			bc_r <= 1'b0;
			bfull_r <= 1'b0;
			txrdy_r <= 1'b0;
			rqrdy_r <= 1'b0;
			width_r <= plk_pkg::LANES_S100;
			rxs_r <= 1'b0;
			rxst_r <= 1'b0;
			rxd_r <= 8'h00;
			pwr_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ctl_r <= ctl_nxt;
			oe_r <= oe_nxt;
			dout_r <= dout_nxt;
			sh_r <= sh_nxt;
			chunks_r <= chunks_nxt;
			last_r <= last_nxt;
			cat_r <= cat_nxt;
			buf_r <= buf_nxt;
			bl_r <= bl_nxt;
			bc_r <= bc_nxt;
			bfull_r <= bfull_nxt;
			txrdy_r <= txrdy_nxt;
			rqrdy_r <= rqrdy_nxt;
			width_r <= width_nxt;
			rxs_r <= rxs_nxt;
			rxst_r <= rxst_nxt;
			rxd_r <= rxd_nxt;
			pwr_r <= pwr_nxt;
		end
	end

	assign link_control_pair_out = ctl_r;
	assign link_control_pair_oe_out = oe_r;
	assign link_data_lanes_out = dout_r;
	assign link_data_lanes_oe_out = oe_r;
	assign link_power_indicator_out = pwr_r;
	assign req_ready_out = rqrdy_r;
	assign tx_ready_out = txrdy_r;
	assign rx_strobe_out = rxs_r;
	assign rx_status_out = rxst_r;
	assign rx_data_out = rxd_r;

	property p_no_rsvd;
		@(posedge sys_clk_in) disable iff (rst_in)
		oe_r |-> ctl_r != plk_pkg::LCTL_RSVD;
	endproperty
	a_no_rsvd: assert property (p_no_rsvd) else $error("reserved code driven");

	property p_drive_after_grant;
		@(posedge sys_clk_in) disable iff (rst_in)
		$rose(oe_r) |-> $past(ctl_s1) == plk_pkg::CTL_GRANT && $past(ph_en);
	endproperty
	a_drive_after_grant: assert property (p_drive_after_grant) else $error("drive w/o grant");

	sequence s_release_edge;
		oe_r && ctl_r == plk_pkg::LCTL_RELEASE && ph_en && pwr_r;
	endsequence
	property p_release_off;
		@(posedge sys_clk_in) disable iff (rst_in)
		s_release_edge |=> !oe_r;
	endproperty
	a_release_off: assert property (p_release_off) else $error("bus kept after release");

	property p_oe_pair;
		@(posedge sys_clk_in) disable iff (rst_in)
		!oe_r && ph_en && pwr_r && ctl_s1 != plk_pkg::CTL_GRANT
			|=> !link_control_pair_oe_out && !link_data_lanes_oe_out;
	endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("buses driven without grant");

	property p_unused_high;
		@(posedge sys_clk_in) disable iff (rst_in)
		oe_r && width_r != plk_pkg::LANES_S400 |->
			dout_r[7:4] == 4'hf && (width_r == plk_pkg::LANES_S200 || dout_r[3:2] == 2'h3);
	endproperty
	a_unused_high: assert property (p_unused_high) else $error("unused lanes not high");

	property p_speed_width;
		@(posedge sys_clk_in) disable iff (rst_in)
		req_take && req_type_in <= plk_pkg::REQ_FAIR && req_speed_in == plk_pkg::SPD_S200
			|=> width_r == plk_pkg::LANES_S200;
	endproperty
	a_speed_width: assert property (p_speed_width) else $error("lane width not from speed");

	property p_rx_seen;
		@(posedge sys_clk_in) disable iff (rst_in)
		ph_en && pwr_r && state_r == ST_OFF && ctl_s1 == plk_pkg::CTL_RECEIVE
			|=> rxs_r && !rxst_r && rxd_r == $past(dat_s1);
	endproperty
	a_rx_seen: assert property (p_rx_seen) else $error("receive symbol lost");

	property p_power_off;
		@(posedge sys_clk_in) disable iff (rst_in)
		!pwr_r ##1 !pwr_r |-> !oe_r && !req_ready_out;
	endproperty
	a_power_off: assert property (p_power_off) else $error("active while powered off");
endmodule : plk_link

// *** plk_phy_model.sv ***
// behavioural phy model facing the link side of the interface
`timescale 1ns/100ps
module plk_phy_model (
	// link pins
	input wire logic [1:0] ctl_link_in,
	input wire logic ctl_oe_in,
	input wire logic [7:0] data_link_in,
	input wire logic data_oe_in,
	// interface clock and wire levels
	output logic phy_clk_out,
	output logic [1:0] ctl_wire_out,
	output logic [7:0] data_wire_out
);
	logic [1:0] ctl_r;
	logic [7:0] data_r;
	initial begin
		phy_clk_out = 1'b0;
		ctl_r = plk_pkg::CTL_IDLE;
		data_r = 8'h00;
		forever #100 phy_clk_out = ~phy_clk_out;
	end
	// phy owns the buses unless the link drives; phy side lanes idle low
	assign ctl_wire_out = ctl_oe_in ? ctl_link_in : ctl_r;
	assign data_wire_out = data_oe_in ? data_link_in : data_r;
	// one symbol launched just after a rise and held one period
	task automatic send(input logic [1:0] c, input logic [7:0] d);
		@(posedge phy_clk_out);
		#1;
		ctl_r = c;
		data_r = d;
		@(posedge phy_clk_out);
		#1;
		ctl_r = plk_pkg::CTL_IDLE;
		data_r = 8'h00;
	endtask : send
endmodule : plk_phy_model

// *** plk_link_test.sv ***
// self-checking bench for the link side of the phy interface
`timescale 1ns/100ps
module plk_link_test;
	logic sys_clk_in, rst_in, power_on_in, req_valid, req_bp, req_acc;
	logic [2:0] req_type, req_speed;
	logic [3:0] req_addr, req_prio;
	logic [7:0] req_data, tx_data, dat_o, dat_w, rx_data;
	logic [1:0] ctl_o, ctl_w;
	logic tx_valid, tx_last, tx_concat, ctl_oe, dat_oe, link_service_request_line, pwr;
	logic req_rdy, tx_rdy, rx_stb, rx_stat, phy_clk;
	int fails = 0;
	int n_compared = 0;
	plk_link DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .phy_supplied_clock_in(phy_clk),
		.link_control_pair_in(ctl_w), .link_control_pair_out(ctl_o),
		.link_control_pair_oe_out(ctl_oe), .link_data_lanes_in(dat_w),
		.link_data_lanes_out(dat_o), .link_data_lanes_oe_out(dat_oe),
		.link_service_request_line_out(link_service_request_line), .link_power_indicator_out(pwr),
		.power_on_in(power_on_in), .req_valid_in(req_valid), .req_type_in(req_type),
		.req_speed_in(req_speed), .req_addr_in(req_addr), .req_data_in(req_data),
		.req_prio_in(req_prio), .req_backplane_in(req_bp), .req_accel_en_in(req_acc),
		.req_ready_out(req_rdy), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
		.tx_last_in(tx_last), .tx_concat_in(tx_concat), .tx_ready_out(tx_rdy),
		.rx_strobe_out(rx_stb), .rx_status_out(rx_stat), .rx_data_out(rx_data));
	plk_phy_model u_phy (.ctl_link_in(ctl_o), .ctl_oe_in(ctl_oe), .data_link_in(dat_o),
		.data_oe_in(dat_oe), .phy_clk_out(phy_clk), .ctl_wire_out(ctl_w),
		.data_wire_out(dat_w));
	initial begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	task automatic put_req(input logic [2:0] t, s, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] p, input logic bp, acc);
		int i;
		@(posedge sys_clk_in);
		#2;
		{req_type, req_speed, req_addr, req_data, req_prio} = {t, s, a, d, p};
		{req_bp, req_acc} = {bp, acc};
		req_valid = 1'b1;
		i = 0;
		do begin
			@(posedge sys_clk_in);
			i++;
		end while (req_rdy !== 1'b1 && i < 400);
		#2;
		req_valid = 1'b0;
		chk(17'(i < 400), 17'h1, "request taken");
	endtask : put_req
	task automatic rq(input logic [2:0] t, s, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] p, input logic bp, acc);
		logic [16:0] e, got;
		int n, i;
		case (t)
			plk_pkg::REQ_RD: begin
				n = 9;
				e = 17'({1'b1, t, a, 1'b0});
			end
			plk_pkg::REQ_WR: begin
				n = 17;
				e = {1'b1, t, a, d, 1'b0};
			end
			plk_pkg::REQ_ACC: begin
				n = 6;
				e = 17'({1'b1, t, acc, 1'b0});
			end
			default: begin
				n = bp ? 11 : 7;
				e = bp ? 17'({1'b1, t, s, p}) : 17'({1'b1, t, s});
			end
		endcase
		put_req(t, s, a, d, p, bp, acc);
		got = '0;
		i = 0;
		do begin
			@(posedge phy_clk);
			i++;
		end while (link_service_request_line !== 1'b1 && i < 40);
		repeat (n) begin
			got = {got[15:0], link_service_request_line};
			@(posedge phy_clk);
		end
		chk(got, e, "request bits");
		chk(17'(link_service_request_line), 17'h0, "stop bit");
	endtask : rq
	task automatic rxs(input logic [1:0] c, input logic [7:0] d);
		int i;
		i = 0;
		fork
			u_phy.send(c, d);
			begin
				do begin
					@(posedge sys_clk_in);
					i++;
				end while (rx_stb !== 1'b1 && i < 40);
				chk({7'h0, rx_stb, rx_stat, rx_data}, {7'h1, c == plk_pkg::CTL_STATUS, d}, "rx");
				@(posedge sys_clk_in);
				chk(17'(rx_stb), 17'h0, "strobe length");
			end
		join
	endtask : rxs
	task automatic tx_push(input logic [7:0] d, input logic l, c);
		int i;
		@(posedge sys_clk_in);
		#2;
		{tx_data, tx_last, tx_concat, tx_valid} = {d, l, c, 1'b1};
		i = 0;
		do begin
			@(posedge sys_clk_in);
			i++;
		end while (tx_rdy !== 1'b1 && i < 400);
		#2;
		tx_valid = 1'b0;
		chk(17'(i < 400), 17'h1, "byte taken");
	endtask : tx_push
	task automatic t_req;
		logic hi;
		rq(plk_pkg::REQ_RD, 3'h0, 4'h9, 8'h00, 4'h0, 1'b0, 1'b0);
		rxs(plk_pkg::CTL_STATUS, 8'h81);
		rq(plk_pkg::REQ_WR, 3'h0, 4'h3, 8'ha6, 4'h0, 1'b0, 1'b0);
		rq(plk_pkg::REQ_ACC, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0, 1'b1);
		rq(plk_pkg::REQ_FAIR, plk_pkg::SPD_S400, 4'h0, 8'h00, 4'hd, 1'b1, 1'b0);
		rq(plk_pkg::REQ_IMM, plk_pkg::SPD_S100, 4'h0, 8'h00, 4'h0, 1'b0, 1'b0);
		rq(plk_pkg::REQ_ISO, plk_pkg::SPD_S400, 4'h0, 8'h00, 4'h0, 1'b0, 1'b0);
		put_req(plk_pkg::REQ_RSVD, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0, 1'b0);
		hi = 1'b0;
		repeat (20) begin
			@(posedge phy_clk);
			hi = hi | link_service_request_line;
		end
		chk(17'(hi), 17'h0, "reserved request sent");
		rq(plk_pkg::REQ_PRI, plk_pkg::SPD_S200, 4'h0, 8'h00, 4'h0, 1'b0, 1'b0);
		rxs(plk_pkg::CTL_RECEIVE, 8'h5a);
		$display("requests done");
	endtask : t_req
	task automatic t_tx;
		logic [9:0] seq[$];
		logic [7:0] ex[4] = '{8'hfa, 8'hf5, 8'hf3, 8'hfc};
		int nt, nh, nr;
		tx_push(8'ha5, 1'b1, 1'b1);
		repeat (5) @(posedge phy_clk);
		chk(17'(ctl_oe | dat_oe), 17'h0, "driven before grant");
		fork
			begin
				u_phy.send(plk_pkg::CTL_GRANT, 8'h00);
				tx_push(8'h3c, 1'b1, 1'b0);
			end
			repeat (16) begin
				@(posedge phy_clk);
				if (ctl_oe === 1'b1)
					seq.push_back({ctl_w, dat_w});
			end
		join
		{nt, nh, nr} = '0;
		foreach (seq[k]) begin
			if (seq[k][9:8] === plk_pkg::LCTL_TRANSMIT) begin
				if (nt < 4)
					chk(17'(seq[k][7:0]), 17'(ex[nt]), "lanes");
				nt++;
			end
			nh += int'(seq[k][9:8] === plk_pkg::LCTL_HOLD && nt == 2);
			nr += int'(seq[k][9:8] === plk_pkg::LCTL_RELEASE);
			chk(17'(seq[k][9:8] === plk_pkg::LCTL_RSVD), 17'h0, "reserved code");
		end
		chk(17'(nt), 17'h4, "transmit count");
		chk(17'(nh > 0), 17'h1, "concatenation hold");
		chk(17'(nr), 17'h1, "release periods");
		chk(17'(seq[0][9:8]), 17'(plk_pkg::LCTL_HOLD), "first code");
		chk(17'(seq[$][9:8]), 17'(plk_pkg::LCTL_RELEASE), "last code");
		chk(17'(ctl_oe | dat_oe), 17'h0, "ownership back");
		$display("transmit done");
	endtask : t_tx
	task automatic t_pwr;
		@(posedge sys_clk_in);
		#2;
		power_on_in = 1'b0;
		repeat (3) @(posedge sys_clk_in);
		#2;
		chk(17'({pwr, req_rdy}), 17'h0, "power off");
		power_on_in = 1'b1;
		repeat (3) @(posedge sys_clk_in);
		#2;
		chk(17'(pwr), 17'h1, "power on");
		$display("power done");
	endtask : t_pwr
	initial begin
		{power_on_in, req_valid, req_bp, req_acc, req_type, req_speed} = '0;
		{req_addr, req_prio, req_data, tx_data, tx_valid, tx_last, tx_concat} = '0;
		rst_in = 1'b1;
		repeat (20) @(posedge sys_clk_in);
		#2;
		chk(17'({ctl_oe, dat_oe, link_service_request_line, pwr, req_rdy, tx_rdy, rx_stb}), 17'h0, "reset");
		rst_in = 1'b0;
		power_on_in = 1'b1;
		$display("reset done");
		t_req;
		t_tx;
		t_pwr;
		results;
	end
	initial begin
		#600000;
		fails++;
		results;
	end
endmodule : plk_link_test
